// ==== verilog/tcm_top.sv ====
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tcm_top
	import tcm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             output_pin_a,
	output logic             output_pin_b,
	output logic             match_a_flag,
	output logic             match_b_flag,
	output logic             match_p_flag
);
	logic [7:0]       compare_a_low_reg;
	logic [1:0]       compare_a_high_reg;
	logic [7:0]       compare_b_low_reg;
	logic [1:0]       compare_b_high_reg;
	logic [7:0]       control_register_one;
	logic [7:0]       control_register_two;
	logic             timer_run_bit;
	logic [2:0]       period_compare_bits;
	logic             run_prev_reg;
	logic [7:0]       aw_addr_reg;
	logic             aw_full_reg;
	logic [31:0]      w_data_reg;
	logic [3:0]       w_strb_reg;
	logic             w_full_reg;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] compare_value_a;
	logic [CNT_W-1:0] compare_value_b;
	logic [CNT_W-1:0] p_point;
	logic [1:0]       chan_a_mode;
	logic [1:0]       chan_b_mode;
	logic             clear_source_select;
	logic             restart;
	logic             counting;
	logic             hit_a;
	logic             hit_b;
	logic             hit_p;
	logic             overflow;
	logic             counter_clr;
	logic             wr_go;
	logic             wr_ok;
	logic [2:0]       clr_bits;
	logic             pin_a_en;
	logic             pin_b_en;
	logic             cmp_like_a;
	logic             cmp_like_b;

	assign compare_value_a     = {compare_a_high_reg, compare_a_low_reg};
	assign compare_value_b     = {compare_b_high_reg, compare_b_low_reg};
	assign chan_a_mode         = control_register_one[C1_MODE_LSB +: 2];
	assign chan_b_mode         = control_register_two[C2_MODE_LSB +: 2];
	assign clear_source_select = control_register_one[C1_CLR_SEL];
	assign restart             = timer_run_bit && !run_prev_reg;
	// A stale count left from before a stop must not match in the restart cycle.
	assign counting            = timer_run_bit && run_prev_reg;

	// Compare-match and timer/counter modes share the counter and flag behaviour.
	assign cmp_like_a = (chan_a_mode == MODE_COMPARE) || (chan_a_mode == MODE_TIMER);
	assign cmp_like_b = (chan_b_mode == MODE_COMPARE) || (chan_b_mode == MODE_TIMER);
	// Only compare-match mode lets a match drive the pins; a restart loads the initial level in every mode.
	assign pin_a_en = (chan_a_mode == MODE_COMPARE);
	assign pin_b_en = (chan_b_mode == MODE_COMPARE);

	// Period zero code means the full 1024 count span, reached through overflow.
	assign p_point  = {period_compare_bits, 7'h00};
	assign hit_a    = counting && (count == compare_value_a);
	assign hit_b    = counting && (count == compare_value_b);
	assign overflow = counting && (count == CNT_MAX);
	assign hit_p    = counting && !clear_source_select
		&& ((period_compare_bits != 3'h0) ? (count == p_point) : overflow);
	assign counter_clr = clear_source_select ? hit_a : hit_p;

	tcm_counter u_counter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.restart (restart),
		.run     (counting),
		.clr     (counter_clr),
		.count   (count)
	);

	tcm_pin u_pin_a (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.restart    (restart),
		.init_level (control_register_one[C1_INIT_BIT]),
		.match      (hit_a),
		.enable     (pin_a_en),
		.action     (control_register_one[C1_ACTION_LSB +: 2]),
		.pin        (output_pin_a)
	);

	tcm_pin u_pin_b (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.restart    (restart),
		.init_level (control_register_two[C2_INIT_BIT]),
		.match      (hit_b),
		.enable     (pin_b_en),
		.action     (control_register_two[C2_ACTION_LSB +: 2]),
		.pin        (output_pin_b)
	);

	// Write channel: address and data are latched independently, then committed together.
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	assign wr_go         = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_ok         = (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg <= ADDR_COUNTER);
	assign clr_bits      = (wr_go && aw_addr_reg == ADDR_FLAGS && w_strb_reg[0])
		? w_data_reg[2:0] : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= 8'h00;
			aw_full_reg <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end else if (wr_go) begin
				aw_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			w_full_reg <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
			end else if (wr_go) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register file; only byte lane 0 carries data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_a_low_reg    <= RESET_BYTE;
			compare_a_high_reg   <= 2'b00;
			compare_b_low_reg    <= RESET_BYTE;
			compare_b_high_reg   <= 2'b00;
			control_register_one <= RESET_BYTE;
			control_register_two <= RESET_BYTE;
			timer_run_bit        <= 1'b0;
			period_compare_bits  <= 3'h0;
		end else if (ce && wr_go && w_strb_reg[0]) begin
			unique case (aw_addr_reg)
				ADDR_CMP_A_LOW:  compare_a_low_reg  <= w_data_reg[7:0];
				ADDR_CMP_A_HIGH: compare_a_high_reg <= w_data_reg[1:0];
				ADDR_CMP_B_LOW:  compare_b_low_reg  <= w_data_reg[7:0];
				ADDR_CMP_B_HIGH: compare_b_high_reg <= w_data_reg[1:0];
				ADDR_CTRL_ONE:   control_register_one <= w_data_reg[7:0];
				ADDR_CTRL_TWO:   control_register_two <= w_data_reg[7:0];
				ADDR_CTRL_RUN: begin
					timer_run_bit       <= w_data_reg[RUN_BIT];
					period_compare_bits <= w_data_reg[RUN_PER_LSB +: 3];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_prev_reg <= 1'b0;
		end else if (ce) begin
			run_prev_reg <= timer_run_bit;
		end
	end

	// Flags: a new match wins over a same-cycle software clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_a_flag <= 1'b0;
			match_b_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end else if (ce) begin
			match_a_flag <= (hit_a && cmp_like_a) || (match_a_flag && !clr_bits[FLAG_A]);
			match_b_flag <= (hit_b && cmp_like_b) || (match_b_flag && !clr_bits[FLAG_B]);
			match_p_flag <= (hit_p && cmp_like_a) || (match_p_flag && !clr_bits[FLAG_P]);
		end
	end

	// Read channel.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					ADDR_CMP_A_LOW:  s_axi_rdata <= {24'h000000, compare_a_low_reg};
					ADDR_CMP_A_HIGH: s_axi_rdata <= {30'h00000000, compare_a_high_reg};
					ADDR_CMP_B_LOW:  s_axi_rdata <= {24'h000000, compare_b_low_reg};
					ADDR_CMP_B_HIGH: s_axi_rdata <= {30'h00000000, compare_b_high_reg};
					ADDR_CTRL_ONE:   s_axi_rdata <= {24'h000000, control_register_one};
					ADDR_CTRL_TWO:   s_axi_rdata <= {24'h000000, control_register_two};
					ADDR_CTRL_RUN:   s_axi_rdata <= {25'h0000000, period_compare_bits,
						3'h0, timer_run_bit};
					ADDR_FLAGS:      s_axi_rdata <= {29'h00000000, match_p_flag,
						match_b_flag, match_a_flag};
					ADDR_COUNTER:    s_axi_rdata <= {22'h000000, count};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : tcm_top

// ==== verilog/tcm_pkg.sv ====
package tcm_pkg;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
	localparam int P_SHIFT = 7;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CMP_A_LOW  = 8'h00;
	localparam logic [7:0] ADDR_CMP_A_HIGH = 8'h04;
	localparam logic [7:0] ADDR_CMP_B_LOW  = 8'h08;
	localparam logic [7:0] ADDR_CMP_B_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_CTRL_ONE   = 8'h10;
	localparam logic [7:0] ADDR_CTRL_TWO   = 8'h14;
	localparam logic [7:0] ADDR_CTRL_RUN   = 8'h18;
	localparam logic [7:0] ADDR_FLAGS      = 8'h1C;
	localparam logic [7:0] ADDR_COUNTER    = 8'h20;

	// Control register one fields.
	localparam int C1_MODE_LSB   = 6;
	localparam int C1_ACTION_LSB = 4;
	localparam int C1_INIT_BIT   = 3;
	localparam int C1_CLR_SEL    = 0;
	// Control register two fields.
	localparam int C2_MODE_LSB   = 6;
	localparam int C2_ACTION_LSB = 4;
	localparam int C2_INIT_BIT   = 3;
	// Run register fields.
	localparam int RUN_BIT       = 0;
	localparam int RUN_PER_LSB   = 4;
	// Flag register fields, write one to clear.
	localparam int FLAG_A        = 0;
	localparam int FLAG_B        = 1;
	localparam int FLAG_P        = 2;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	localparam logic [1:0] MODE_COMPARE = 2'b00;
	localparam logic [1:0] MODE_CAPTURE = 2'b01;
	localparam logic [1:0] MODE_PWM     = 2'b10;
	localparam logic [1:0] MODE_TIMER   = 2'b11;

	localparam logic [1:0] ACT_NONE   = 2'b00;
	localparam logic [1:0] ACT_LOW    = 2'b01;
	localparam logic [1:0] ACT_HIGH   = 2'b10;
	localparam logic [1:0] ACT_TOGGLE = 2'b11;
endpackage : tcm_pkg

// ==== verilog/tcm_pin.sv ====
`timescale 1ns/1ps
module tcm_pin
	import tcm_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic       restart,
	input  wire logic       init_level,
	input  wire logic       match,
	input  wire logic       enable,
	input  wire logic [1:0] action,
	output logic            pin
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				pin <= init_level;
			end else if (match && enable) begin
				unique case (action)
					ACT_NONE:   pin <= pin;
					ACT_LOW:    pin <= 1'b0;
					ACT_HIGH:   pin <= 1'b1;
					ACT_TOGGLE: pin <= ~pin;
				endcase
			end
		end
	end
endmodule : tcm_pin

// ==== verilog/tcm_counter.sv ====
`timescale 1ns/1ps
module tcm_counter
	import tcm_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	input  wire logic             restart,
	input  wire logic             run,
	input  wire logic             clr,
	output logic [CNT_W-1:0]      count
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (ce) begin
			if (restart || clr) begin
				count <= '0;
			end else if (run) begin
				count <= count + 10'h001;
			end
		end
	end
endmodule : tcm_counter

// ==== verification/tcm_top_sva.sv ====
`timescale 1ns/1ps
module tcm_chk
	import tcm_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        output_pin_a,
	input wire logic        output_pin_b,
	input wire logic        match_a_flag,
	input wire logic        match_b_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		ce && s_axi_arvalid && s_axi_arready;
	endsequence
	// A restart is written through the bus, so a pin may also move just after a write answer.
	sequence wr_recent;
		s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endsequence
	a_wr_answer: assert property (wr_taken ##1 ce |=> s_axi_bvalid)
		else $error("write answer missing");
	a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer missing");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	a_high_zero: assert property (rd_taken ##0 (s_axi_araddr == ADDR_CMP_A_HIGH ||
		s_axi_araddr == ADDR_CMP_B_HIGH) |=> s_axi_rdata[31:2] == 30'h0)
		else $error("high byte upper bits not zero");
	a_bad_addr: assert property (rd_taken ##0 (s_axi_araddr > ADDR_COUNTER)
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_flag_sticky: assert property ($fell(match_a_flag) |-> $rose(s_axi_bvalid))
		else $error("flag a fell without a write");
	a_pin_a_cause: assert property ($changed(output_pin_a) && !match_a_flag |-> wr_recent)
		else $error("pin a moved without a match");
	a_pin_b_cause: assert property ($changed(output_pin_b) && !match_b_flag |-> wr_recent)
		else $error("pin b moved without a match");
endmodule : tcm_chk

bind tcm_top tcm_chk u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.output_pin_a, .output_pin_b, .match_a_flag, .match_b_flag);

// ==== verification/tcm_pin_load.sv ====
`timescale 1ns/1ps
// Load on the two pins: counts every level change it sees on each.
module tcm_pin_load (
	input  wire logic aclk,
	input  wire logic pin_a,
	input  wire logic pin_b,
	output int        edges_a,
	output int        edges_b
);
	logic prev_a = 1'b0;
	logic prev_b = 1'b0;
	int   cnt_a  = 0;
	int   cnt_b  = 0;
	assign edges_a = cnt_a;
	assign edges_b = cnt_b;
	always @(posedge aclk) begin
		if (pin_a !== prev_a) cnt_a <= cnt_a + 1;
		if (pin_b !== prev_b) cnt_b <= cnt_b + 1;
		prev_a <= pin_a;
		prev_b <= pin_b;
	end
endmodule : tcm_pin_load

// ==== verification/tb_timer_compare_match_output.sv ====
`timescale 1ns/1ps
module tb_timer_compare_match_output;
	import tcm_pkg::*;
	logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, init;
	logic        s_axi_rvalid, output_pin_a, output_pin_b, match_a_flag, match_b_flag, match_p_flag;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	int          mismatches = 0;
	int          checks = 0;
	int          edges_a, edges_b, seed, e0, e1;
	int          cmp_model [4];

	tcm_top dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .output_pin_a, .output_pin_b, .match_a_flag, .match_b_flag,
		.match_p_flag);
	tcm_pin_load load_u (.aclk, .pin_a(output_pin_a), .pin_b(output_pin_b), .edges_a, .edges_b);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_word(what, {31'h0, exp}, {31'h0, got});
	endtask : chk_bit

	task automatic summarize();
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask : bus_rd

	// Stops the timer, clears all flags, loads both controls and restarts.
	task automatic start(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] run);
		bus_wr(ADDR_CTRL_RUN, 32'h0);
		bus_wr(ADDR_FLAGS, 32'h7);
		bus_wr(ADDR_CTRL_ONE, {24'h0, c1});
		bus_wr(ADDR_CTRL_TWO, {24'h0, c2});
		bus_wr(ADDR_CTRL_RUN, {24'h0, run});
		repeat (2) @(posedge aclk);
	endtask : start

	function automatic logic pin_exp(input int act, input logic lvl);
		case (act)
			0: return lvl;
			1: return 1'b0;
			2: return 1'b1;
			default: return ~lvl;
		endcase
	endfunction : pin_exp

	initial begin
		ce = 1'b1;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		seed = $urandom(2);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus_rd(8'(4 * i));
			chk_word("cmp_reset", 32'h0, rd);
		end
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			cmp_model[i] = d & ((i % 2) ? 32'h3 : 32'hFF);
			bus_wr(8'(4 * i), d);
			bus_rd(8'(4 * i));
			chk_word("cmp_value", cmp_model[i], rd);
		end
		bus_rd(8'h40);
		chk_word("bad_rd_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		chk_word("bad_rd_data", 32'h0, rd);
		bus_wr(8'h40, 32'hFF);
		chk_word("bad_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		bus_wr(ADDR_CMP_A_LOW, 32'hC8);
		bus_wr(ADDR_CMP_A_HIGH, 32'h0);
		bus_wr(ADDR_CMP_B_LOW, 32'h64);
		bus_wr(ADDR_CMP_B_HIGH, 32'h0);
		for (int act = 0; act < 4; act++) begin
			init = 1'($urandom % 2);
			start({MODE_COMPARE, 2'(act), init, 3'b001}, {MODE_COMPARE, 2'(act), init, 3'b000},
				8'h11);
			chk_bit("pin_a_init", init, output_pin_a);
			chk_bit("pin_b_init", init, output_pin_b);
			for (int w = 0; w < 2000 && match_a_flag !== 1'b1; w++) begin
				@(posedge aclk);
			end
			@(posedge aclk);
			chk_bit("flag_a_seen", 1'b1, match_a_flag);
			chk_bit("pin_a_match", pin_exp(act, init), output_pin_a);
			chk_bit("pin_b_match", pin_exp(act, init), output_pin_b);
			chk_bit("flag_b", 1'b1, match_b_flag);
			chk_bit("flag_p_off", 1'b0, match_p_flag);
		end
		start({MODE_COMPARE, ACT_LOW, 1'b1, 3'b000}, {MODE_COMPARE, ACT_LOW, 1'b1, 3'b000},
			8'h21);
		repeat (600) @(posedge aclk);
		chk_bit("flag_a", 1'b1, match_a_flag);
		chk_bit("flag_p", 1'b1, match_p_flag);
		chk_bit("pin_a_low", 1'b0, output_pin_a);
		bus_wr(ADDR_FLAGS, 32'h4);
		chk_bit("flag_p_clr", 1'b0, match_p_flag);
		chk_bit("flag_a_kept", 1'b1, match_a_flag);
		bus_wr(ADDR_CTRL_RUN, 32'h0);
		bus_wr(ADDR_CTRL_RUN, 32'h21);
		repeat (2) @(posedge aclk);
		chk_bit("pin_a_restart", 1'b1, output_pin_a);
		start({MODE_COMPARE, ACT_NONE, 1'b0, 3'b001}, {MODE_COMPARE, ACT_NONE, 1'b0, 3'b000}, 8'h11);
		for (int m = 1; m < 4; m++) begin
			e0 = edges_a;
			e1 = edges_b;
			start({2'(m), ACT_TOGGLE, 1'b0, 3'b001}, {2'(m), ACT_TOGGLE, 1'b0, 3'b000}, 8'h11);
			repeat (400) @(posedge aclk);
			chk_word("pin_a_edges", 32'(e0), 32'(edges_a));
			chk_word("pin_b_edges", 32'(e1), 32'(edges_b));
			chk_bit("flag_a_mode", m == 3, match_a_flag);
		end
		// Period code zero: the P flag comes only from the overflow at the top count.
		start({MODE_COMPARE, ACT_HIGH, 1'b0, 3'b000}, {MODE_COMPARE, ACT_HIGH, 1'b0, 3'b000},
			8'h01);
		repeat (1000) @(posedge aclk);
		chk_bit("flag_p_early", 1'b0, match_p_flag);
		repeat (40) @(posedge aclk);
		chk_bit("flag_p_ovf", 1'b1, match_p_flag);
		chk_bit("pin_a_high", 1'b1, output_pin_a);
		chk_bit("pin_b_high", 1'b1, output_pin_b);
		summarize();
	end

	initial begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		summarize();
	end
endmodule : tb_timer_compare_match_output
